/* File: adcsp_consts.vh */
/*
  Constants for the converter serial port and conversion control block.
  Assumes inclusion by bare name from the design files.
*/
`ifndef ADCSP_CONSTS_VH
`define ADCSP_CONSTS_VH

// ----------------------------------------
// Control word layout
// ----------------------------------------
`define ADCSP_CTRL_W          10
`define ADCSP_BIT_EXT_REF     0
`define ADCSP_BIT_SW_CONV     1
`define ADCSP_BIT_CHAN_LO     2
`define ADCSP_BIT_CHAN_HI     3
`define ADCSP_BIT_PAIRING     4
`define ADCSP_BIT_COMMON      5
`define ADCSP_BIT_PWR_LO      6
`define ADCSP_BIT_PWR_HI      7
`define ADCSP_BIT_ADDR        8
`define ADCSP_CTRL_RESET      10'h000

// ----------------------------------------
// Power mode codes
// ----------------------------------------
`define ADCSP_PWR_FULL_NOW    2'h0
`define ADCSP_PWR_PART_EOC    2'h1
`define ADCSP_PWR_FULL_EOC    2'h2
`define ADCSP_PWR_UP          2'h3

// ----------------------------------------
// Serial frame counts
// ----------------------------------------
`define ADCSP_WR_BITS         4'ha
`define ADCSP_WR_PULSES       4'hd
`define ADCSP_RD_RELEASE      4'hb
`define ADCSP_RES_W           10

// ----------------------------------------
// Conversion timing
// ----------------------------------------
`define ADCSP_CLK_MHZ         50
`define ADCSP_CONV_NS         2300
`define ADCSP_CONV_CYC        ((`ADCSP_CONV_NS * `ADCSP_CLK_MHZ) / 1000)

`endif

/* File: adcsp_fifo.v */
/*
  Small synchronous FIFO carrying conversion results to the serial port.
  Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/100ps
module adcsp_fifo #(
  parameter WIDTH = 10,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  // Clock and reset
  input  wire             core_clk_i,
  input  wire             arst_n_i,
  // Fill side
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  // Drain side
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output reg  [WIDTH-1:0] out_data_o
);

  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_reg;
  reg [AW-1:0]    rd_ptr_reg;
  reg [AW:0]      count_reg;
  reg             out_valid_reg;
  wire            push;
  wire            pop_mem;
  wire            load_out;
  wire [AW:0]     used;

  // Output stage counts toward depth, so full means DEPTH words held
  assign used        = count_reg + {{AW{1'b0}}, out_valid_reg};
  assign in_ready_o  = (used != DEPTH[AW:0]);
  assign push        = in_valid_i & in_ready_o;
  assign out_valid_o = out_valid_reg;
  // Registered output stage refilled when empty or being taken
  assign load_out    = (~out_valid_reg | out_ready_i);
  assign pop_mem     = load_out & (count_reg != {(AW+1){1'b0}});

  always @(posedge core_clk_i)
  begin
    if (push)
      mem_reg[wr_ptr_reg] <= in_data_i;
  end

  always @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      wr_ptr_reg    <= {AW{1'b0}};
      rd_ptr_reg    <= {AW{1'b0}};
      count_reg     <= {(AW+1){1'b0}};
      out_valid_reg <= 1'b0;
      out_data_o    <= {WIDTH{1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
      if (pop_mem)
      begin
        rd_ptr_reg <= rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
        out_data_o <= mem_reg[rd_ptr_reg];
      end
      if (load_out)
        out_valid_reg <= pop_mem;
      if (push & ~pop_mem)
        count_reg <= count_reg + {{AW{1'b0}}, 1'b1};
      else if (pop_mem & ~push)
        count_reg <= count_reg - {{AW{1'b0}}, 1'b1};
    end
  end

endmodule // adcsp_fifo

/* File: adcsp_top.v */
/*
  Serial port and conversion control of a 10-bit sampling converter.
  Assumes the host drives shift clock, frame syncs and serial input
  asynchronously; all are synchronised to core_clk_i. The analog core
  returns a result word on conv_result_i when a conversion ends.
*/
// Operation
// [RL1] Control frame sync fall: shift control word in on next 10 clock falls.
// [RL2] Host gives 13 clock pulses per write; only first 10 bits kept.
// [RL3] Shift clock ignored until a rising read frame sync edge arms counter.
// [RL4] Bit counter cleared after each read; next read needs new sync edge.
// [RL5] Serial output changes on each rising shift clock edge.
// [RL6] Serial output released on rising edge of eleventh read clock pulse.
// [RL7] Serial input sampled on falling edges, output driven on rising edges.
// [RL8] Conversion trigger fall enters hold and starts a conversion; the code ignores it while the power code is full now.
// [RL9] Trigger level at end of conversion decides power-down.
// [RL10] Address pin combines with control word address bit for bus sharing.
// [RL11] Host sets external reference bit when external reference used.
// [RL12] Ten-bit write-only control word with documented field order.
// [RL13] Mismatching address discards word; only last addressed device drives.
// [RL14] Power codes: full now, partial at end, full at end, power up.
// [RL15] Control word resets to zero, leaving device fully powered down.
// [RL16] New control word applied only after its tenth bit is captured.
`timescale 1ns/100ps
`include "adcsp_consts.vh"
module adcsp_top #(
  parameter CTRL_W   = 10,
  parameter RES_W    = 10,
  parameter FIFO_D   = 4,
  parameter CONV_CYC = `ADCSP_CONV_CYC
) (
  // Clock and reset
  input  wire              core_clk_i,
  input  wire              arst_n_i,
  // Serial link pins
  input  wire              shift_clk_i,
  input  wire              control_frame_sync_i,
  input  wire              read_frame_sync_i,
  input  wire              serial_in_i,
  output reg               serial_out_o,
  output reg               serial_out_oe_n_o,
  // Conversion and address pins
  input  wire              conversion_trigger_i,
  input  wire              package_address_pin_i,
  // Analog core side
  input  wire [RES_W-1:0]  conv_result_i,
  output reg               track_hold_o,
  output reg               converting_o,
  output reg               full_power_down_o,
  output reg               partial_power_down_o,
  output reg               external_ref_select_o,
  output reg               channel_select_hi_o,
  output reg               channel_select_lo_o,
  output reg               input_pairing_select_o,
  output reg               common_input_select_o,
  // Status
  output wire              result_fifo_full_o
);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  reg [4:0] sync1_reg;
  reg [4:0] sync2_reg;
  reg [4:0] prev_reg;
  always @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sync1_reg <= 5'h1f;
      sync2_reg <= 5'h1f;
      prev_reg  <= 5'h1f;
    end
    else
    begin
      sync1_reg <= {shift_clk_i, control_frame_sync_i, read_frame_sync_i,
                    serial_in_i, conversion_trigger_i};
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  wire sclk_s   = sync2_reg[4];
  wire din_s    = sync2_reg[1];
  wire trig_s   = sync2_reg[0];
  wire sclk_rise = sclk_s & ~prev_reg[4];
  wire sclk_fall = ~sclk_s & prev_reg[4];
  wire cfs_fall  = ~sync2_reg[3] & prev_reg[3];
  wire rfs_rise  = sync2_reg[2] & ~prev_reg[2];
  wire trig_fall = ~trig_s & prev_reg[0];

  // Address bit must match the strapped pin; pin synchronised like the rest
  reg [1:0] addr_sync_reg;
  always @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      addr_sync_reg <= 2'h0;
    else
      addr_sync_reg <= {addr_sync_reg[0], package_address_pin_i};
  end

  // ----------------------------------------
  // Control word write
  // ----------------------------------------
  reg [CTRL_W-1:0] shift_in_reg;
  reg [CTRL_W-1:0] ctrl_reg;
  reg [3:0]        wr_cnt_reg;
  reg              wr_act_reg;
  reg              selected_reg;
  always @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      shift_in_reg <= {CTRL_W{1'b0}};
      ctrl_reg     <= `ADCSP_CTRL_RESET; // RL15
      wr_cnt_reg   <= 4'h0;
      wr_act_reg   <= 1'b0;
      selected_reg <= 1'b0;
    end
    else if (cfs_fall)
    begin
      wr_act_reg <= 1'b1; // RL1
      wr_cnt_reg <= 4'h0;
    end
    else if (wr_act_reg & sclk_fall)
    begin
      wr_cnt_reg <= wr_cnt_reg + 4'h1;
      // Pulses 11 to 13 only finish the frame; bits dropped
      if (wr_cnt_reg < `ADCSP_WR_BITS) // RL2
        shift_in_reg <= {shift_in_reg[CTRL_W-2:0], din_s}; // RL7
      if (wr_cnt_reg == `ADCSP_WR_BITS - 4'h1)
      begin
        // Apply only once the tenth bit is in
        if (shift_in_reg[`ADCSP_BIT_ADDR-1] == addr_sync_reg[1]) // RL10
        begin
          ctrl_reg     <= {shift_in_reg[CTRL_W-2:0], din_s}; // RL16
          selected_reg <= 1'b1; // RL13
        end
        else
          selected_reg <= 1'b0; // RL13
      end
      if (wr_cnt_reg == `ADCSP_WR_PULSES - 4'h1)
        wr_act_reg <= 1'b0; // RL2
    end
  end

  wire [1:0] pwr_mode = {ctrl_reg[`ADCSP_BIT_PWR_HI], ctrl_reg[`ADCSP_BIT_PWR_LO]}; // RL12

  always @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      external_ref_select_o  <= 1'b0;
      channel_select_hi_o    <= 1'b0;
      channel_select_lo_o    <= 1'b0;
      input_pairing_select_o <= 1'b0;
      common_input_select_o  <= 1'b0;
    end
    else
    begin
      external_ref_select_o  <= ctrl_reg[`ADCSP_BIT_EXT_REF]; // RL12
      channel_select_hi_o    <= ctrl_reg[`ADCSP_BIT_CHAN_HI];
      channel_select_lo_o    <= ctrl_reg[`ADCSP_BIT_CHAN_LO];
      input_pairing_select_o <= ctrl_reg[`ADCSP_BIT_PAIRING];
      common_input_select_o  <= ctrl_reg[`ADCSP_BIT_COMMON];
    end
  end

  // ----------------------------------------
  // Conversion control
  // ----------------------------------------
  localparam ST_IDLE = 3'b001;
  localparam ST_CONV = 3'b010;
  localparam ST_DOWN = 3'b100;

  reg [2:0]  state_reg;
  reg [11:0] conv_cnt_reg;
  reg        sw_start_reg;
  wire       fifo_in_ready;
  reg        push_reg;
  reg [RES_W-1:0] push_data_reg;

  // Software convert bit pulses once each time it goes from 0 to 1
  wire sw_conv = ctrl_reg[`ADCSP_BIT_SW_CONV] & ~sw_start_reg;
  wire start   = trig_fall | sw_conv; // RL8

  always @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_reg            <= ST_DOWN;
      conv_cnt_reg         <= 12'h000;
      sw_start_reg         <= 1'b0;
      track_hold_o         <= 1'b0;
      converting_o         <= 1'b0;
      full_power_down_o    <= 1'b1; // RL15
      partial_power_down_o <= 1'b0;
      push_reg             <= 1'b0;
      push_data_reg        <= {RES_W{1'b0}};
    end
    else
    begin
      sw_start_reg <= ctrl_reg[`ADCSP_BIT_SW_CONV];
      if (push_reg & fifo_in_ready)
        push_reg <= 1'b0;
      case (state_reg)
        ST_IDLE, ST_DOWN:
        begin
          if (pwr_mode == `ADCSP_PWR_FULL_NOW) // RL14
          begin
            full_power_down_o    <= 1'b1;
            partial_power_down_o <= 1'b0;
            state_reg            <= ST_DOWN;
          end
          else if (start)
          begin
            // A start in any power mode but full-now wakes the core and enters hold
            full_power_down_o    <= 1'b0;
            partial_power_down_o <= 1'b0;
            track_hold_o         <= 1'b1; // RL8
            converting_o         <= 1'b1;
            conv_cnt_reg         <= CONV_CYC[11:0];
            state_reg            <= ST_CONV;
          end
          else if (pwr_mode == `ADCSP_PWR_UP) // RL14
          begin
            full_power_down_o    <= 1'b0;
            partial_power_down_o <= 1'b0;
            state_reg            <= ST_IDLE;
          end
        end
        ST_CONV:
        begin
          if (conv_cnt_reg > 12'h001)
            conv_cnt_reg <= conv_cnt_reg - 12'h001;
          else
          begin
            track_hold_o  <= 1'b0;
            converting_o  <= 1'b0;
            // Full FIFO drops newest result rather than stalling the core
            push_reg      <= fifo_in_ready;
            push_data_reg <= conv_result_i;
            // Trigger low at end selects power-down unless overridden
            if (pwr_mode == `ADCSP_PWR_FULL_NOW) // RL14
            begin
              full_power_down_o <= 1'b1;
              state_reg         <= ST_DOWN;
            end
            else if (~trig_s & (pwr_mode != `ADCSP_PWR_UP)) // RL9
            begin
              full_power_down_o    <= (pwr_mode == `ADCSP_PWR_FULL_EOC);
              partial_power_down_o <= (pwr_mode == `ADCSP_PWR_PART_EOC);
              state_reg            <= ST_DOWN;
            end
            else
              state_reg <= ST_IDLE;
          end
        end
        default:
          state_reg <= ST_DOWN;
      endcase
    end
  end

  // ----------------------------------------
  // Result buffer
  // ----------------------------------------
  wire             fifo_out_valid;
  wire [RES_W-1:0] fifo_out_data;
  reg              fifo_take;

  assign result_fifo_full_o = ~fifo_in_ready;

  adcsp_fifo #(
    .WIDTH (RES_W),
    .DEPTH (FIFO_D),
    .AW    (2)
  ) u_fifo (
    .core_clk_i  (core_clk_i),
    .arst_n_i    (arst_n_i),
    .in_valid_i  (push_reg),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (push_data_reg),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_take),
    .out_data_o  (fifo_out_data)
  );

  // ----------------------------------------
  // Serial read
  // ----------------------------------------
  reg [RES_W-1:0] shift_out_reg;
  reg [3:0]       rd_cnt_reg;
  reg             rd_act_reg;
  always @*
  begin
    fifo_take = rfs_rise & selected_reg & fifo_out_valid;
  end

  always @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      shift_out_reg     <= {RES_W{1'b0}};
      rd_cnt_reg        <= 4'h0;
      rd_act_reg        <= 1'b0;
      serial_out_o      <= 1'b0;
      serial_out_oe_n_o <= 1'b1;
    end
    else if (rfs_rise)
    begin
      rd_act_reg <= selected_reg; // RL3
      rd_cnt_reg <= 4'h0;
      if (fifo_take)
        shift_out_reg <= fifo_out_data;
      else
        shift_out_reg <= {RES_W{1'b0}};
    end
    else if (rd_act_reg & sclk_rise)
    begin
      rd_cnt_reg <= rd_cnt_reg + 4'h1;
      if (rd_cnt_reg == `ADCSP_RD_RELEASE - 4'h1)
      begin
        serial_out_oe_n_o <= 1'b1; // RL6
        rd_act_reg        <= 1'b0; // RL4
        rd_cnt_reg        <= 4'h0; // RL4
      end
      else
      begin
        serial_out_oe_n_o <= 1'b0;
        serial_out_o      <= shift_out_reg[RES_W-1]; // RL5
        shift_out_reg     <= {shift_out_reg[RES_W-2:0], 1'b0};
      end
    end
  end

endmodule // adcsp_top

/* File: adcsp_top_asserts.sv */
/*
  Port-level checker for the converter serial port block.
  Assumes a bench link clock of eight core cycles and a three-cycle
  pin-to-edge latency in the design.
*/
`timescale 1ns/100ps
module adcsp_top_asserts #(
  parameter CONV_CYC = 115
) (
  // Clock and reset
  input wire core_clk_i,
  input wire arst_n_i,
  // Pins
  input wire shift_clk_i,
  input wire conversion_trigger_i,
  input wire serial_out_o,
  input wire serial_out_oe_n_o,
  // Core side
  input wire track_hold_o,
  input wire converting_o,
  input wire full_power_down_o,
  input wire partial_power_down_o,
  input wire external_ref_select_o,
  input wire channel_select_lo_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  // ----------------------------------------
  // Helper counters
  // ----------------------------------------
  reg         sck_reg;
  reg [3:0]   rises_reg;
  integer     conv_reg;
  always @(posedge core_clk_i or negedge arst_n_i)
    if (!arst_n_i)
    begin
      sck_reg   <= 1'b1;
      rises_reg <= 4'h0;
      conv_reg  <= 0;
    end
    else
    begin
      sck_reg   <= shift_clk_i;
      rises_reg <= serial_out_oe_n_o ? 4'h0 : rises_reg + {3'h0, shift_clk_i & ~sck_reg};
      conv_reg  <= converting_o ? conv_reg + 1 : 0;
    end
  property p_out_on_rise;
    $changed(serial_out_o) && !serial_out_oe_n_o |-> $past(shift_clk_i, 3);
  endproperty
  a_out_on_rise: assert property (p_out_on_rise) else $error("data moved off a rising clock");
  property p_drive_start;
    $fell(serial_out_oe_n_o) |-> $past(shift_clk_i, 3) && !$past(shift_clk_i, 7);
  endproperty
  a_drive_start: assert property (p_drive_start) else $error("drive began off a rising clock");
  property p_release;
    $rose(serial_out_oe_n_o) |-> rises_reg == 4'ha;
  endproperty
  a_release: assert property (p_release) else $error("release not at rise eleven");
  property p_trig_hold;
    $fell(conversion_trigger_i) |-> ##[3:5] (track_hold_o && converting_o);
  endproperty
  a_trig_hold: assert property (p_trig_hold) else $error("trigger fall gave no hold");
  property p_conv_len;
    $fell(converting_o) |-> conv_reg == CONV_CYC;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");
  property p_conv_up;
    converting_o |-> !full_power_down_o && !partial_power_down_o;
  endproperty
  a_conv_up: assert property (p_conv_up) else $error("powered down while converting");
  property p_pd_end;
    $fell(converting_o) && conversion_trigger_i |-> (!partial_power_down_o) [*4];
  endproperty
  a_pd_end: assert property (p_pd_end) else $error("partial down with trigger high");
  property p_pd_excl;
    !(full_power_down_o && partial_power_down_o);
  endproperty
  a_pd_excl: assert property (p_pd_excl) else $error("two power modes at once");
  property p_cfg_on_fall;
    $changed({external_ref_select_o, channel_select_lo_o}) |-> !$past(shift_clk_i, 3);
  endproperty
  a_cfg_on_fall: assert property (p_cfg_on_fall) else $error("config moved off a falling clock");
endmodule // adcsp_top_asserts

/* File: adcsp_host.sv */
/*
  Host serial port model: writes control words, reads results.
  Assumes it is called from a process sitting on a core clock edge.
*/
`timescale 1ns/100ps
module adcsp_host (
  // Clock
  input  wire core_clk_i,
  // Link toward the device
  output reg  shift_clk_o,
  output reg  control_frame_sync_o,
  output reg  read_frame_sync_o,
  output reg  serial_in_o,
  // Device answer
  input  wire serial_out_i,
  input  wire serial_out_oe_n_i
);
  initial
  begin
    shift_clk_o          = 1'b1;
    control_frame_sync_o = 1'b1;
    read_frame_sync_o    = 1'b1;
    serial_in_o          = 1'b0;
  end
  task half;
    begin
      repeat (4) @(posedge core_clk_i);
    end
  endtask
  task wr(input [9:0] w);
    integer k;
    begin
      control_frame_sync_o <= 1'b0;
      half;
      for (k = 0; k < 13; k = k + 1)
      begin
        // Trailing bits inverted so a wrong pick shows
        serial_in_o <= (k < 10) ? w[9-k] : ~w[k-10];
        half;
        shift_clk_o <= 1'b0;
        half;
        shift_clk_o <= 1'b1;
      end
      control_frame_sync_o <= 1'b1;
      serial_in_o          <= ~serial_in_o;
      half;
      half;
    end
  endtask
  task rd(input arm, output [9:0] d, output drove);
    integer k;
    begin
      d     = 10'h000;
      drove = 1'b0;
      if (arm)
      begin
        read_frame_sync_o <= 1'b0;
        half;
        read_frame_sync_o <= 1'b1;
        half;
      end
      for (k = 0; k < 11; k = k + 1)
      begin
        shift_clk_o <= 1'b0;
        half;
        // Sample late in the low half, well after the change
        if (k > 0)
        begin
          // A released line reads inverted so a read off the drive window shows
          d     = {d[8:0], serial_out_oe_n_i ? ~serial_out_i : serial_out_i};
          drove = drove | ~serial_out_oe_n_i;
        end
        shift_clk_o <= 1'b1;
        half;
      end
      half;
    end
  endtask
endmodule // adcsp_host

/* File: adc_serial_port_and_convert_control_test.sv */
/*
  Self-checking bench for the converter serial port block.
  Assumes the host model and checker files are compiled first.
*/
`timescale 1ns/100ps
module adc_serial_port_and_convert_control_test;
  localparam CONV = 8;
  reg        core_clk_i = 1'b0;
  reg        arst_n_i = 1'b0;
  reg        conversion_trigger_i = 1'b1;
  reg        package_address_pin_i = 1'b0;
  reg  [9:0] conv_result_i = 10'h000;
  wire       shift_clk_i, control_frame_sync_i, read_frame_sync_i, serial_in_i;
  wire       serial_out_o, serial_out_oe_n_o, track_hold_o, converting_o;
  wire       full_power_down_o, partial_power_down_o, external_ref_select_o;
  wire       channel_select_hi_o, channel_select_lo_o, input_pairing_select_o;
  wire       common_input_select_o, result_fifo_full_o;
  wire [9:0] cfg = {serial_out_oe_n_o, partial_power_down_o, converting_o, track_hold_o,
                    external_ref_select_o, channel_select_hi_o, channel_select_lo_o,
                    input_pairing_select_o, common_input_select_o, full_power_down_o};
  integer    bad_count = 0;
  integer    n_tests = 0;
  reg  [9:0] d;
  reg  [9:0] k;
  reg        seen;
  always #10 core_clk_i = ~core_clk_i;
  adcsp_top #(.CONV_CYC(CONV)) dut (
    .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .shift_clk_i(shift_clk_i),
    .control_frame_sync_i(control_frame_sync_i), .read_frame_sync_i(read_frame_sync_i),
    .serial_in_i(serial_in_i), .serial_out_o(serial_out_o), .serial_out_oe_n_o(serial_out_oe_n_o),
    .conversion_trigger_i(conversion_trigger_i), .package_address_pin_i(package_address_pin_i),
    .conv_result_i(conv_result_i), .track_hold_o(track_hold_o), .converting_o(converting_o),
    .full_power_down_o(full_power_down_o), .partial_power_down_o(partial_power_down_o),
    .external_ref_select_o(external_ref_select_o), .channel_select_hi_o(channel_select_hi_o),
    .channel_select_lo_o(channel_select_lo_o), .input_pairing_select_o(input_pairing_select_o),
    .common_input_select_o(common_input_select_o), .result_fifo_full_o(result_fifo_full_o));
  adcsp_host host (
    .core_clk_i(core_clk_i), .shift_clk_o(shift_clk_i), .control_frame_sync_o(control_frame_sync_i),
    .read_frame_sync_o(read_frame_sync_i), .serial_in_o(serial_in_i), .serial_out_i(serial_out_o),
    .serial_out_oe_n_i(serial_out_oe_n_o));
  task chkb(input got, input exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp)
      begin
        bad_count = bad_count + 1;
        $display("unexpected at %0t: flag %b", $time, got);
      end
    end
  endtask
  task chkw(input [9:0] got, input [9:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp)
      begin
        bad_count = bad_count + 1;
        $display("unexpected at %0t: word %h not %h", $time, got, exp);
      end
    end
  endtask
  task convert(input [9:0] r, input lvl, input [1:0] pd);
    begin
      conv_result_i        <= r;
      conversion_trigger_i <= 1'b0;
      repeat (3) @(posedge core_clk_i);
      conversion_trigger_i <= lvl;
      repeat (4) @(posedge core_clk_i);
      chkb(track_hold_o, 1'b1);
      chkb(converting_o, 1'b1);
      repeat (CONV + 6) @(posedge core_clk_i);
      chkb(full_power_down_o, pd[1]);
      chkb(partial_power_down_o, pd[0]);
      conversion_trigger_i <= 1'b1;
      repeat (4) @(posedge core_clk_i);
    end
  endtask
  task give_verdict;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial
  begin
    repeat (12) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    chkw(cfg, 10'h201);
    host.wr(10'h1fd);
    chkw(cfg, 10'h201);
    host.wr(10'h0fd);
    chkw(cfg, 10'h23e);
    host.rd(1'b0, d, seen);
    chkb(seen, 1'b0);
    for (k = 0; k < 4; k = k + 1)
      convert(10'h2a5 + k, 1'b1, 2'b00);
    convert(10'h3ff, 1'b1, 2'b00);
    chkb(result_fifo_full_o, 1'b1);
    // Fifth result was dropped; reads return order then zeros
    for (k = 0; k < 5; k = k + 1)
    begin
      host.rd(1'b1, d, seen);
      chkw(d, (k < 4) ? 10'h2a5 + k : 10'h000);
      chkb(serial_out_oe_n_o, 1'b1);
    end
    chkb(result_fifo_full_o, 1'b0);
    host.wr(10'h041);
    convert(10'h111, 1'b0, 2'b01);
    host.wr(10'h081);
    convert(10'h222, 1'b0, 2'b10);
    host.wr(10'h0c1);
    convert(10'h333, 1'b0, 2'b00);
    host.wr(10'h001);
    chkw(cfg, 10'h221);
    package_address_pin_i <= 1'b1;
    host.wr(10'h0fd);
    chkw(cfg, 10'h221);
    host.rd(1'b1, d, seen);
    chkb(seen, 1'b0);
    host.wr(10'h1c1);
    chkw(cfg, 10'h220);
    // Software convert bit starts one conversion; results come out in order
    conv_result_i <= 10'h155;
    host.wr(10'h1c3);
    chkb(result_fifo_full_o, 1'b1);
    for (k = 0; k < 4; k = k + 1)
    begin
      host.rd(1'b1, d, seen);
      chkw(d, (k < 3) ? 10'h111 * (k + 1) : 10'h155);
    end
    give_verdict;
  end
  initial
  begin
    #400000;
    bad_count = bad_count + 1;
    $display("unexpected at %0t: run hung", $time);
    give_verdict;
  end
endmodule // adc_serial_port_and_convert_control_test
bind adcsp_top adcsp_top_asserts #(.CONV_CYC(CONV_CYC)) u_chk (
  .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .shift_clk_i(shift_clk_i),
  .conversion_trigger_i(conversion_trigger_i), .serial_out_o(serial_out_o),
  .serial_out_oe_n_o(serial_out_oe_n_o), .track_hold_o(track_hold_o), .converting_o(converting_o),
  .full_power_down_o(full_power_down_o), .partial_power_down_o(partial_power_down_o),
  .external_ref_select_o(external_ref_select_o), .channel_select_lo_o(channel_select_lo_o));
